// [rtl/ptf_token_framer.sv]
// Purpose: Takes 8-bit tokens from the transmit queue and turns them into a symbol stream.
// Assumes: Queue writes, reads and the start bit are single-cycle strobes on core_clk.
// Notes: Output symbols are kinds plus nibbles; 4b5b and BMC coding sit downstream.

`timescale 1ns/1ps

// Functional notes
// - Tokens and payload are exchanged as 8-bit bytes through the queue register.
// - One token is taken from the queue head and finished before the next.
// - Symbol tokens are translated to line symbol kinds, never sent raw.
// - Transmitter-on command write starts transmission like the start bit, not queued.
// - Tokens 12h, 13h, 1Bh send one Sync-1, Sync-2, Sync-3 symbol.
// - Tokens 15h and 16h send one RST-1 and one RST-2 symbol.
// - Header 100xxxxx takes the next N queue bytes as payload, N from low bits.
// - Each payload byte goes out as two nibbles, low nibble first, for 4b5b.
// - Token FFh inserts the hardware-computed packet CRC into the stream.
// - Token 14h sends one EOP symbol.
// - Token FEh disables the line driver; software places it after EOP.
// - Queue register writes push the transmit queue; reads pop the receive queue.
// - Full and empty flags of the transmit queue are reported.
module ptf_token_framer
  import ptf_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic queue_wr,
  input wire logic [7:0] queue_wdata,
  input wire logic queue_rd,
  output logic [7:0] queue_rdata,
  output logic rx_pop,
  input wire logic [7:0] rx_head,
  input wire logic tx_start,
  output logic tx_full,
  output logic tx_empty,
  output logic driver_en,
  output logic sym_valid,
  input wire logic sym_ready,
  output ptf_sym_t sym_kind,
  output logic [3:0] sym_nibble
);

  // ****************************************
  // Transmit queue
  // ****************************************
  logic [7:0] queue_mem [PTF_QUEUE_DEPTH];
  logic [PTF_QUEUE_AW-1:0] wr_ptr;
  logic [PTF_QUEUE_AW-1:0] rd_ptr;
  logic [PTF_QUEUE_AW:0] level;
  logic is_on_cmd;
  logic push;
  logic pop;
  logic [7:0] head;
  ptf_state_t state;
  logic [PTF_PACKED_COUNT_W-1:0] pay_left;
  logic [7:0] pay_byte;
  logic [2:0] crc_idx;
  logic [31:0] crc;
  logic [31:0] crc_out;
  logic start_req;
  logic sym_take;

  assign is_on_cmd = (queue_wdata & PTF_TRANSMITTER_ON_MASK) == PTF_TRANSMITTER_ON_COMMAND;
  // A write that meets a full queue is dropped; the full flag is the only warning.
  assign push = queue_wr && !is_on_cmd && !tx_full;
  assign pop = ((state == PTF_ST_FETCH) || (state == PTF_ST_PAY_WAIT)) && !tx_empty;
  assign head = queue_mem[rd_ptr];
  assign tx_full = level == PTF_QUEUE_FULL_LEVEL;
  assign tx_empty = level == '0;
  assign start_req = tx_start || (queue_wr && is_on_cmd);
  assign sym_take = sym_valid && sym_ready;

  genvar gi;
  generate
    for (gi = 0; gi < PTF_QUEUE_DEPTH; gi++) begin : g_entry
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          queue_mem[gi] <= '0;
        end else if (push && (wr_ptr == PTF_QUEUE_AW'(gi))) begin
          queue_mem[gi] <= queue_wdata;
        end
      end
    end
  endgenerate

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr <= '0;
    end else if (push) begin
      wr_ptr <= (wr_ptr == PTF_QUEUE_LAST) ? '0 : wr_ptr + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rd_ptr <= '0;
    end else if (pop) begin
      rd_ptr <= (rd_ptr == PTF_QUEUE_LAST) ? '0 : rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      level <= '0;
    end else if (push && !pop) begin
      level <= level + 1'b1;
    end else if (pop && !push) begin
      level <= level - 1'b1;
    end
  end

  // ****************************************
  // Receive side of the queue register
  // ****************************************
  // The receive queue itself lives elsewhere; a read pops it and latches its head.
  assign rx_pop = queue_rd;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      queue_rdata <= '0;
    end else if (queue_rd) begin
      queue_rdata <= rx_head;
    end
  end

  // ****************************************
  // Token sequencer
  // ****************************************
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= PTF_ST_IDLE;
    end else begin
      case (state)
        PTF_ST_IDLE: begin
          if (start_req) begin
            state <= PTF_ST_FETCH;
          end
        end
        PTF_ST_FETCH: begin
          if (pop) begin
            if (head[PTF_PACKED_TAG_MSB:PTF_PACKED_TAG_LSB] == PTF_PACKED_DATA_HEADER_TAG) begin
              // A zero count is outside the allowed range; it is skipped harmlessly.
              state <= (head[PTF_PACKED_COUNT_W-1:0] == '0) ? PTF_ST_FETCH
                                                           : PTF_ST_PAY_WAIT;
            end else begin
              case (head)
                PTF_SYNC1_SYMBOL_TOKEN, PTF_SYNC2_SYMBOL_TOKEN, PTF_SYNC3_SYMBOL_TOKEN,
                PTF_RST1_SYMBOL_TOKEN, PTF_RST2_SYMBOL_TOKEN, PTF_EOP_TOKEN: begin
                  state <= PTF_ST_KSYM;
                end
                PTF_CRC_INSERT_TOKEN: begin
                  state <= PTF_ST_CRC;
                end
                PTF_DRIVER_OFF_TOKEN: begin
                  state <= PTF_ST_IDLE;
                end
                default: begin
                  state <= PTF_ST_FETCH;
                end
              endcase
            end
          end
        end
        PTF_ST_KSYM: begin
          if (sym_ready) begin
            state <= PTF_ST_FETCH;
          end
        end
        PTF_ST_PAY_WAIT: begin
          if (pop) begin
            state <= PTF_ST_NIB_LO;
          end
        end
        PTF_ST_NIB_LO: begin
          if (sym_ready) begin
            state <= PTF_ST_NIB_HI;
          end
        end
        PTF_ST_NIB_HI: begin
          if (sym_ready) begin
            state <= (pay_left == '0) ? PTF_ST_FETCH : PTF_ST_PAY_WAIT;
          end
        end
        PTF_ST_CRC: begin
          if (sym_ready && (crc_idx == PTF_CRC_LAST_NIBBLE)) begin
            state <= PTF_ST_FETCH;
          end
        end
        default: begin
          state <= PTF_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      driver_en <= 1'b0;
    end else if (state == PTF_ST_IDLE && start_req) begin
      driver_en <= 1'b1;
    end else if (state == PTF_ST_FETCH && pop && head == PTF_DRIVER_OFF_TOKEN) begin
      driver_en <= 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pay_left <= '0;
    end else if (state == PTF_ST_FETCH && pop) begin
      pay_left <= head[PTF_PACKED_COUNT_W-1:0];
    end else if (state == PTF_ST_PAY_WAIT && pop) begin
      pay_left <= pay_left - 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pay_byte <= '0;
    end else if (state == PTF_ST_PAY_WAIT && pop) begin
      pay_byte <= head;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      crc_idx <= '0;
    end else if (state != PTF_ST_CRC) begin
      crc_idx <= '0;
    end else if (sym_ready) begin
      crc_idx <= crc_idx + 1'b1;
    end
  end

  // ****************************************
  // CRC accumulator
  // ****************************************
  function automatic logic [31:0] ptf_crc_nibble(input logic [31:0] c, input logic [3:0] n);
    logic [31:0] r;
    logic fb;
    r = c;
    fb = 1'b0;
    // Bits enter in line order, least significant first.
    for (int b = 0; b < 4; b++) begin
      fb = r[31] ^ n[b];
      r = {r[30:0], 1'b0} ^ (fb ? PTF_CRC_POLY : '0);
    end
    return r;
  endfunction

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      crc <= PTF_CRC_INIT;
    end else if (state == PTF_ST_KSYM && sym_kind != PTF_SYM_EOP) begin
      crc <= PTF_CRC_INIT;
    end else if (sym_take && sym_kind == PTF_SYM_DATA && state != PTF_ST_CRC) begin
      crc <= ptf_crc_nibble(crc, sym_nibble);
    end
  end

  always_comb begin
    crc_out = '0;
    for (int b = 0; b < 32; b++) begin
      crc_out[b] = ~crc[31-b];
    end
  end

  // ****************************************
  // Symbol output
  // ****************************************
  assign sym_valid = (state == PTF_ST_KSYM) || (state == PTF_ST_NIB_LO) ||
                     (state == PTF_ST_NIB_HI) || (state == PTF_ST_CRC);

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sym_kind <= PTF_SYM_DATA;
    end else if (state == PTF_ST_FETCH && pop) begin
      case (head)
        PTF_SYNC1_SYMBOL_TOKEN: sym_kind <= PTF_SYM_SYNC1;
        PTF_SYNC2_SYMBOL_TOKEN: sym_kind <= PTF_SYM_SYNC2;
        PTF_SYNC3_SYMBOL_TOKEN: sym_kind <= PTF_SYM_SYNC3;
        PTF_RST1_SYMBOL_TOKEN: sym_kind <= PTF_SYM_RST1;
        PTF_RST2_SYMBOL_TOKEN: sym_kind <= PTF_SYM_RST2;
        PTF_EOP_TOKEN: sym_kind <= PTF_SYM_EOP;
        default: sym_kind <= PTF_SYM_DATA;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sym_nibble <= '0;
    end else if (state == PTF_ST_PAY_WAIT && pop) begin
      sym_nibble <= head[3:0];
    end else if (state == PTF_ST_NIB_LO && sym_ready) begin
      sym_nibble <= pay_byte[7:4];
    end else if (state == PTF_ST_FETCH && pop && head == PTF_CRC_INSERT_TOKEN) begin
      sym_nibble <= crc_out[3:0];
    end else if (state == PTF_ST_CRC && sym_ready) begin
      sym_nibble <= crc_out[{crc_idx + 3'h1, 2'h0} +: 4];
    end else if (state == PTF_ST_FETCH) begin
      sym_nibble <= '0;
    end
  end

endmodule

// [rtl/ptf_pkg.sv]
// Purpose: Shared constants and types for the transmit token framer.
// Assumes: Tokens arrive as bytes on the core clock from the serial register logic.
// Notes: Symbol kinds are handed on unencoded; the line coder maps them to 5-bit codes.

package ptf_pkg;

  // ****************************************
  // Token codes
  // ****************************************
  localparam logic [7:0] PTF_SYNC1_SYMBOL_TOKEN = 8'h12;
  localparam logic [7:0] PTF_SYNC2_SYMBOL_TOKEN = 8'h13;
  localparam logic [7:0] PTF_SYNC3_SYMBOL_TOKEN = 8'h1B;
  localparam logic [7:0] PTF_RST1_SYMBOL_TOKEN = 8'h15;
  localparam logic [7:0] PTF_RST2_SYMBOL_TOKEN = 8'h16;
  localparam logic [7:0] PTF_EOP_TOKEN = 8'h14;
  localparam logic [7:0] PTF_CRC_INSERT_TOKEN = 8'hFF;
  localparam logic [7:0] PTF_DRIVER_OFF_TOKEN = 8'hFE;
  localparam logic [7:0] PTF_TRANSMITTER_ON_MASK = 8'hE1;
  localparam logic [7:0] PTF_TRANSMITTER_ON_COMMAND = 8'hA1;
  localparam logic [2:0] PTF_PACKED_DATA_HEADER_TAG = 3'h4;
  localparam int PTF_PACKED_TAG_MSB = 7;
  localparam int PTF_PACKED_TAG_LSB = 5;
  localparam int PTF_PACKED_COUNT_W = 5;

  // ****************************************
  // Queue geometry
  // ****************************************
  localparam int PTF_QUEUE_DEPTH = 48;
  localparam int PTF_QUEUE_AW = 6;
  localparam logic [PTF_QUEUE_AW-1:0] PTF_QUEUE_LAST = 6'h2F;
  localparam logic [PTF_QUEUE_AW:0] PTF_QUEUE_FULL_LEVEL = 7'h30;

  // ****************************************
  // CRC
  // ****************************************
  localparam logic [31:0] PTF_CRC_POLY = 32'h04C11DB7;
  localparam logic [31:0] PTF_CRC_INIT = 32'hFFFFFFFF;
  localparam logic [2:0] PTF_CRC_LAST_NIBBLE = 3'h7;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [2:0] {
    PTF_SYM_DATA,
    PTF_SYM_SYNC1,
    PTF_SYM_SYNC2,
    PTF_SYM_SYNC3,
    PTF_SYM_RST1,
    PTF_SYM_RST2,
    PTF_SYM_EOP
  } ptf_sym_t;

  typedef enum logic [2:0] {
    PTF_ST_IDLE,
    PTF_ST_FETCH,
    PTF_ST_KSYM,
    PTF_ST_PAY_WAIT,
    PTF_ST_NIB_LO,
    PTF_ST_NIB_HI,
    PTF_ST_CRC
  } ptf_state_t;

endpackage

// [sim/ptf_framer_props.sv]
// Purpose: Port checks for the transmit token framer.
// Assumes: One clock domain, nrst asynchronous and active low.
// Notes: Attached by bind from the bench top file.
`timescale 1ns/1ps
module ptf_framer_props
  import ptf_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic queue_wr,
  input wire logic [7:0] queue_wdata,
  input wire logic queue_rd,
  input wire logic [7:0] queue_rdata,
  input wire logic rx_pop,
  input wire logic [7:0] rx_head,
  input wire logic tx_start,
  input wire logic tx_full,
  input wire logic tx_empty,
  input wire logic driver_en,
  input wire logic sym_valid,
  input wire logic sym_ready,
  input wire ptf_sym_t sym_kind,
  input wire logic [3:0] sym_nibble
);
  wire logic cmd_wr = queue_wr && ((queue_wdata & PTF_TRANSMITTER_ON_MASK) == 8'hA1);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  a_pop_tracks_read: assert property (rx_pop == queue_rd)
    else $error("rx_pop does not follow queue_rd");
  a_read_latch: assert property (queue_rd |=> queue_rdata == $past(rx_head))
    else $error("queue_rdata is not the popped head");
  a_offer_holds: assert property (sym_valid && !sym_ready |=>
    sym_valid && $stable(sym_kind) && $stable(sym_nibble))
    else $error("symbol offer changed before acceptance");
  a_flags_exclusive: assert property (!(tx_full && tx_empty))
    else $error("full and empty both high");
  a_write_fills: assert property (queue_wr && !cmd_wr && tx_empty |=> !tx_empty)
    else $error("queued byte not counted");
  a_cmd_not_queued: assert property (cmd_wr && tx_empty |=> tx_empty)
    else $error("start command was queued");
  a_start_drives: assert property ((tx_start || cmd_wr) && !driver_en |=> driver_en)
    else $error("start did not enable driver");
  a_quiet_when_off: assert property (!driver_en |-> !sym_valid)
    else $error("symbol offered with driver off");
endmodule

// [sim/ptf_sym_sink.sv]
// Purpose: Line coder stand-in that takes symbols and logs them.
// Assumes: Handshake completes on a rising edge with valid and ready high.
// Notes: The bench reads the log queue got directly.
`timescale 1ns/1ps
module ptf_sym_sink
  import ptf_pkg::*;
(
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic slow,
  input wire logic sym_valid,
  input wire ptf_sym_t sym_kind,
  input wire logic [3:0] sym_nibble,
  output logic sym_ready
);
  logic [6:0] got[$];
  logic phase;
  // A slow coder accepts only every other cycle, which stretches each offer.
  assign sym_ready = !slow || phase;
  always @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      phase <= 1'b0;
    end else begin
      phase <= !phase;
      if (sym_valid && sym_ready) begin
        got.push_back({sym_kind, sym_nibble});
      end
    end
  end
endmodule

// [sim/ptf_token_framer_tb_top.sv]
// Purpose: Self-checking bench for the transmit token framer.
// Assumes: Inputs change 1 ns after the rising edge.
// Notes: Expected symbols and CRC are rebuilt here from the token stream.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) begin n_tests++; if ((gt) !== (ex)) begin bad_count++; \
  $display("Error %s expected %0h seen %0h", nm, ex, gt); end end
module ptf_token_framer_tb_top
  import ptf_pkg::*;
;
  logic core_clk, nrst, queue_wr, queue_rd, tx_start, sym_ready, slow;
  logic rx_pop, tx_full, tx_empty, driver_en, sym_valid;
  logic [7:0] queue_wdata, rx_head, queue_rdata;
  logic [3:0] sym_nibble;
  ptf_sym_t sym_kind;
  int bad_count = 0;
  int n_tests = 0;
  logic [6:0] exp_q[$];
  logic [31:0] crc;

  ptf_token_framer u_dut (.core_clk(core_clk), .nrst(nrst), .queue_wr(queue_wr),
    .queue_wdata(queue_wdata), .queue_rd(queue_rd), .queue_rdata(queue_rdata),
    .rx_pop(rx_pop), .rx_head(rx_head), .tx_start(tx_start), .tx_full(tx_full),
    .tx_empty(tx_empty), .driver_en(driver_en), .sym_valid(sym_valid),
    .sym_ready(sym_ready), .sym_kind(sym_kind), .sym_nibble(sym_nibble));
  ptf_sym_sink u_sink (.core_clk(core_clk), .nrst(nrst), .slow(slow), .sym_valid(sym_valid),
    .sym_kind(sym_kind), .sym_nibble(sym_nibble), .sym_ready(sym_ready));

  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  // Bytes go in back to back; the strobe is dropped only after the last one.
  task automatic load(input logic [7:0] bs[$]);
    foreach (bs[i]) begin
      queue_wdata = bs[i];
      queue_wr = 1'b1;
      tick(1);
    end
    queue_wr = 1'b0;
  endtask

  task automatic exp_sym(input ptf_sym_t k, input logic [3:0] n);
    exp_q.push_back({k, (k == PTF_SYM_DATA) ? n : 4'h0});
    if (k == PTF_SYM_DATA) begin
      for (int i = 0; i < 4; i++) begin
        crc = {crc[30:0], 1'b0} ^ ((crc[31] ^ n[i]) ? PTF_CRC_POLY : 32'h0);
      end
    end else if (k != PTF_SYM_EOP) begin
      crc = PTF_CRC_INIT;
    end
  endtask

  task automatic finish_pkt(input string nm);
    int i;
    logic [6:0] e;
    logic [6:0] g;
    i = 0;
    while (driver_en !== 1'b0 && i < 3000) begin
      tick(1);
      i++;
    end
    if (i == 3000) begin
      bad_count++;
      results();
    end
    `CHK({nm, " count"}, exp_q.size(), u_sink.got.size())
    while (exp_q.size() > 0 && u_sink.got.size() > 0) begin
      e = exp_q.pop_front();
      g = u_sink.got.pop_front();
      `CHK(nm, e, g & ((e[6:4] == PTF_SYM_DATA) ? 7'h7F : 7'h70))
    end
    exp_q.delete();
    u_sink.got.delete();
  endtask

  task automatic t_packet(input int n);
    logic [7:0] q[$];
    logic [31:0] r;
    crc = PTF_CRC_INIT;
    q = '{8'h12, 8'h12, 8'h12, 8'h13, {3'b100, 5'(n)}};
    repeat (3) exp_sym(PTF_SYM_SYNC1, 4'h0);
    exp_sym(PTF_SYM_SYNC2, 4'h0);
    for (int i = 0; i < n; i++) begin
      q.push_back(8'(i * 37 + 5));
      exp_sym(PTF_SYM_DATA, 4'(i * 37 + 5));
      exp_sym(PTF_SYM_DATA, 4'((i * 37 + 5) >> 4));
    end
    for (int j = 0; j < 32; j++) r[j] = ~crc[31 - j];
    for (int j = 0; j < 8; j++) exp_q.push_back({PTF_SYM_DATA, r[4 * j +: 4]});
    exp_sym(PTF_SYM_EOP, 4'h0);
    q.push_back(8'hFF);
    q.push_back(8'h14);
    q.push_back(8'hFE);
    q.push_back(8'hA1);
    load(q);
    finish_pkt("packet");
    `CHK("cmd not kept", 1'b1, tx_empty)
  endtask

  task automatic t_symbols();
    slow = 1'b1;
    exp_sym(PTF_SYM_SYNC3, 4'h0);
    exp_sym(PTF_SYM_RST1, 4'h0);
    exp_sym(PTF_SYM_RST2, 4'h0);
    exp_sym(PTF_SYM_EOP, 4'h0);
    load('{8'h1B, 8'h15, 8'h00, 8'h16, 8'h14, 8'hFE});
    tx_start = 1'b1;
    tick(1);
    tx_start = 1'b0;
    finish_pkt("symbols");
    slow = 1'b0;
  endtask

  task automatic t_full();
    logic [7:0] q[$];
    repeat (47) q.push_back(8'h00);
    q.push_back(8'hFE);
    load(q);
    `CHK("full", 1'b1, tx_full)
    // Let one edge pass so the strobe is not dropped and raised in one time step.
    tick(1);
    load('{8'h12});
    tx_start = 1'b1;
    tick(1);
    tx_start = 1'b0;
    finish_pkt("drain");
    `CHK("dropped", 1'b1, tx_empty)
  endtask

  task automatic t_read();
    rx_head = 8'hA3;
    queue_rd = 1'b1;
    #1;
    `CHK("rx_pop", 1'b1, rx_pop)
    tick(1);
    // A second read follows back to back with a new head byte.
    rx_head = 8'h5C;
    `CHK("rdata first", 8'hA3, queue_rdata)
    tick(1);
    queue_rd = 1'b0;
    rx_head = 8'h00;
    `CHK("rdata", 8'h5C, queue_rdata)
    `CHK("rx_pop idle", 1'b0, rx_pop)
    tick(1);
    `CHK("rdata hold", 8'h5C, queue_rdata)
    load('{8'hA1});
    tick(3);
    `CHK("driver on", 1'b1, driver_en)
    `CHK("cmd empty", 1'b1, tx_empty)
    load('{8'hFE});
    finish_pkt("off");
  endtask

  task automatic results();
    $display("Comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    nrst = 1'b0;
    queue_wr = 1'b0;
    queue_rd = 1'b0;
    tx_start = 1'b0;
    slow = 1'b0;
    queue_wdata = 8'h00;
    rx_head = 8'h00;
    tick(20);
    nrst = 1'b1;
    tick(1);
    `CHK("reset empty", 1'b1, tx_empty)
    `CHK("reset driver", 1'b0, driver_en)
    t_packet(2);
    t_packet(30);
    t_symbols();
    t_full();
    t_read();
    results();
  end
endmodule

bind ptf_token_framer ptf_framer_props u_props (.core_clk(core_clk), .nrst(nrst),
  .queue_wr(queue_wr), .queue_wdata(queue_wdata), .queue_rd(queue_rd),
  .queue_rdata(queue_rdata), .rx_pop(rx_pop), .rx_head(rx_head), .tx_start(tx_start),
  .tx_full(tx_full), .tx_empty(tx_empty), .driver_en(driver_en), .sym_valid(sym_valid),
  .sym_ready(sym_ready), .sym_kind(sym_kind), .sym_nibble(sym_nibble));
